// *** test/ssr_host_model.sv ***
// Host controller model: one status command at a time, strobes one cycle long.
`timescale 1ns/10ps
`default_nettype none
module ssr_host_model (
  input  wire logic  clk_in,
  output logic       wr_out, rd_out, preset_out,
  output logic [2:0] set_out, reg_out,
  output logic [15:0] wdata_out);
  initial {wr_out, rd_out, preset_out, set_out, reg_out, wdata_out} = '0;
  // Values sent stay within 0..32767; a gap cycle follows each command
  task automatic cmd(input logic w, r, p, input logic [2:0] s, g, input logic [15:0] d);
    @(posedge clk_in);
    {wr_out, rd_out, preset_out, set_out, reg_out, wdata_out} <= {w, r, p, s, g, d};
    @(posedge clk_in);
    {wr_out, rd_out, preset_out} <= 3'h0;
  endtask : cmd
endmodule : ssr_host_model
`default_nettype wire

// *** test/ssr_status_sets_asserts.sv ***
// Port checker for ssr_status_sets; bound to the top module below.
`timescale 1ns/10ps
`default_nettype none
module ssr_chk import ssr_pkg::*; (
  input wire logic         sys_clk_in, rstn_in, wr_in, rd_in, status_preset_in, rvalid_out,
  input wire logic [104:0] cond_in,
  input wire logic [2:0]   set_sel_in, reg_sel_in,
  input wire logic [15:0]  wdata_in, rdata_out,
  input wire logic [6:0]   summary_out);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  rv_pulse_a: assert property (rd_in |=> rvalid_out) else $error("read unanswered");
  rv_only_a: assert property (!rd_in |=> !rvalid_out) else $error("stray rvalid");
  top_bit_a: assert property (rvalid_out |-> !rdata_out[15]) else $error("bit 15 set");
  rd_hold_a: assert property (!rvalid_out |-> $stable(rdata_out)) else $error("rdata moved");
  bad_sel_a: assert property (rd_in && reg_sel_in > 3'h4 |=> rdata_out == 16'h0000)
    else $error("unknown register read nonzero");
  preset_en_a: assert property (status_preset_in |=> (summary_out & ~SSR_PRE_EN_ONES) == 7'h00)
    else $error("summary after preset");
  en_zero_a: assert property (wr_in && !status_preset_in && reg_sel_in == SSR_REG_ENAB &&
    set_sel_in < 3'h7 && wdata_in[14:0] == 15'h0000 |=> !summary_out[$past(set_sel_in)])
    else $error("summary with zero enable");
  rst_zero_a: assert property ($rose(rstn_in) |-> summary_out == 7'h00 && !rvalid_out)
    else $error("outputs not reset");
endmodule : ssr_chk
bind ssr_status_sets ssr_chk chk_u (.sys_clk_in, .rstn_in, .wr_in, .rd_in, .status_preset_in,
  .rvalid_out, .cond_in, .set_sel_in, .reg_sel_in, .wdata_in, .rdata_out, .summary_out);
`default_nettype wire

// *** test/tb_ssr_status_sets.sv ***
// Bench for ssr_status_sets: host model issues commands, bench drives condition bits.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_ssr_status_sets;
  import ssr_pkg::*;
  logic         sys_clk_in, rstn_in, wr, rd, pre, rvalid;
  logic [2:0]   set, rg;
  logic [15:0]  wd, rdata;
  logic [104:0] cond;
  logic [6:0]   summ;
  int           error_cnt = 0, tests_run = 0;
  ssr_host_model host_u (.clk_in(sys_clk_in), .wr_out(wr), .rd_out(rd), .preset_out(pre),
    .set_out(set), .reg_out(rg), .wdata_out(wd));
  ssr_status_sets dut_u (.sys_clk_in, .rstn_in, .cond_in(cond), .wr_in(wr), .rd_in(rd),
    .set_sel_in(set), .reg_sel_in(rg), .wdata_in(wd), .status_preset_in(pre),
    .rdata_out(rdata), .rvalid_out(rvalid), .summary_out(summ));
  task automatic rd_chk(input logic [2:0] s, g, input logic [15:0] e);
    host_u.cmd(1'b0, 1'b1, 1'b0, s, g, 16'h0000);
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : rd_chk
  function automatic logic [15:0] wval(input int s, g);
    return 16'h7FFF - 16'(s * 9 + g);
  endfunction : wval
  task automatic t_rw();
    for (int s = 0; s < 7; s++) for (int g = 2; g < 5; g++) begin
      host_u.cmd(1'b1, 1'b0, 1'b0, 3'(s), 3'(g), wval(s, g));
      rd_chk(3'(s), 3'(g), wval(s, g));
    end
    rd_chk(SSR_OPER, 3'h7, 16'h0000);
  endtask : t_rw
  task automatic t_pre();
    host_u.cmd(1'b0, 1'b0, 1'b1, 3'h0, 3'h0, 16'h0000);
    for (int s = 0; s < 7; s++) begin
      rd_chk(3'(s), SSR_REG_ENAB, (s > 2 && s < 6) ? 16'h7FFF : 16'h0000);
      rd_chk(3'(s), SSR_REG_PTR, s < 6 ? 16'h7FFF : wval(s, 3));
      rd_chk(3'(s), SSR_REG_NTR, s < 6 ? 16'h0000 : wval(s, 4));
    end
  endtask : t_pre
  task automatic t_evt();
    host_u.cmd(1'b1, 1'b0, 1'b0, SSR_OPER, SSR_REG_NTR, 16'h0004);
    host_u.cmd(1'b1, 1'b0, 1'b0, SSR_OPER, SSR_REG_ENAB, 16'h0010);
    cond[34] <= 1'b1;
    cond[32] <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    `CHK("summary", 1'b1, summ[2])
    rd_chk(SSR_OPER, SSR_REG_COND, 16'h0014);
    rd_chk(SSR_OPER, SSR_REG_COND, 16'h0014);
    rd_chk(SSR_OPER, SSR_REG_EVNT, 16'h0014);
    rd_chk(SSR_OPER, SSR_REG_EVNT, 16'h0000);
    `CHK("summary", 1'b0, summ[2])
    cond[34] <= 1'b0;
    cond[32] <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    rd_chk(SSR_OPER, SSR_REG_EVNT, 16'h0004);
    host_u.cmd(1'b1, 1'b0, 1'b0, SSR_OPER, SSR_REG_PTR, 16'h0010);
    cond[34] <= 1'b1;
    cond[32] <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    rd_chk(SSR_OPER, SSR_REG_EVNT, 16'h0010);
  endtask : t_evt
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    rstn_in = 1'b0;
    cond = '0;
    repeat (10) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    t_rw();
    t_pre();
    t_evt();
    complete_run();
  end
endmodule : tb_ssr_status_sets
`default_nettype wire

// *** verilog/ssr_pkg.sv ***
// Constants and types for the status register sets block.
// Assumes a command decoder outside turns host status commands into strobes.
package ssr_pkg;
  localparam int unsigned      SSR_BITS    = 15;
  localparam int unsigned      SSR_SETS    = 7;
  localparam int unsigned      SSR_SEL_W   = 3;
  localparam logic [14:0]      SSR_ONES    = 15'h7FFF;
  localparam logic [14:0]      SSR_ZERO    = 15'h0000;
  // Set selector codes
  localparam logic [2:0]       SSR_DEVICE  = 3'h0;
  localparam logic [2:0]       SSR_QDATA   = 3'h1;
  localparam logic [2:0]       SSR_OPER    = 3'h2;
  localparam logic [2:0]       SSR_LIMIT   = 3'h3;
  localparam logic [2:0]       SSR_QFREQ   = 3'h4;
  localparam logic [2:0]       SSR_QPOWER  = 3'h5;
  localparam logic [2:0]       SSR_USER    = 3'h6;
  // Register selector codes within a set
  localparam logic [2:0]       SSR_REG_COND = 3'h0;
  localparam logic [2:0]       SSR_REG_EVNT = 3'h1;
  localparam logic [2:0]       SSR_REG_ENAB = 3'h2;
  localparam logic [2:0]       SSR_REG_PTR  = 3'h3;
  localparam logic [2:0]       SSR_REG_NTR  = 3'h4;
  // Preset kind per set: 1 = enables all ones, 0 = enables cleared
  localparam logic [6:0]       SSR_PRE_EN_ONES = 7'h38;
  typedef logic [14:0] ssr_word_t;
  typedef struct packed {
    ssr_word_t [SSR_SETS-1:0] cond;
    ssr_word_t [SSR_SETS-1:0] evnt;
    ssr_word_t [SSR_SETS-1:0] enab;
    ssr_word_t [SSR_SETS-1:0] ptr;
    ssr_word_t [SSR_SETS-1:0] ntr;
    ssr_word_t                rdata;
    logic                     rvalid;
  } ssr_state_t;
endpackage : ssr_pkg

// *** verilog/ssr_status_sets.sv ***
// Seven status register sets: condition, event, enable, transition filters.
// Condition inputs are synchronised here; command strobes come from logic on
// sys_clk_in and are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for a bus of independent level bits
module ssr_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] safe;
  } ssr_sync_t;

  ssr_sync_t sy_q;
  ssr_sync_t sy_d;

  // Only the second stage reads the first, which may still be settling
  always_comb begin
    sy_d.meta = async_in;
    sy_d.safe = sy_q.meta;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sy_q <= '0;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign sync_out = sy_q.safe;
endmodule : ssr_sync2

// Filtered edge detector for one set: rising edges pass where the positive
// filter bit is one, falling edges where the negative filter bit is one
module ssr_edge_filt #(
  parameter int unsigned WIDTH = 15
) (
  // Present and previous condition bits
  input  wire logic [WIDTH-1:0] now_in,
  input  wire logic [WIDTH-1:0] old_in,
  // Transition filters
  input  wire logic [WIDTH-1:0] ptr_in,
  input  wire logic [WIDTH-1:0] ntr_in,
  // Bits whose event latch must set
  output logic      [WIDTH-1:0] hit_out
);

  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  assign rise    = now_in & ~old_in & ptr_in;
  assign fall    = ~now_in & old_in & ntr_in;
  assign hit_out = rise | fall;
endmodule : ssr_edge_filt

// Summary of one set: any latched event whose enable bit is one
module ssr_summary #(
  parameter int unsigned WIDTH = 15
) (
  // Event and enable words of the set
  input  wire logic [WIDTH-1:0] event_in,
  input  wire logic [WIDTH-1:0] enable_in,
  // Summary flag
  output logic                  flag_out
);

  assign flag_out = |(event_in & enable_in);
endmodule : ssr_summary

module ssr_status_sets (
  // Clock and reset
  input  wire logic                                           sys_clk_in,
  input  wire logic                                           rstn_in,
  // Condition bits from the instrument, asynchronous
  input  wire logic [ssr_pkg::SSR_SETS*ssr_pkg::SSR_BITS-1:0] cond_in,
  // Command port
  input  wire logic                                           wr_in,
  input  wire logic                                           rd_in,
  input  wire logic [ssr_pkg::SSR_SEL_W-1:0]                  set_sel_in,
  input  wire logic [ssr_pkg::SSR_SEL_W-1:0]                  reg_sel_in,
  input  wire logic [15:0]                                    wdata_in,
  input  wire logic                                           status_preset_in,
  // Answers
  output logic [15:0]                                         rdata_out,
  output logic                                                rvalid_out,
  output logic [ssr_pkg::SSR_SETS-1:0]                        summary_out
);
  import ssr_pkg::*;

  localparam int unsigned COND_W = SSR_SETS * SSR_BITS;

  logic [COND_W-1:0] cond_sync;
  ssr_word_t         hit     [SSR_SETS];
  logic              sum_bit [SSR_SETS];
  ssr_state_t        st_q;
  ssr_state_t        st_d;

  // Read-back of one register of one set; codes outside the table read zero
  function automatic ssr_word_t pick_word(input ssr_state_t st, input int s,
                                          input logic [SSR_SEL_W-1:0] sel);
    ssr_word_t w;
    w = SSR_ZERO;
    unique case (sel)
      SSR_REG_COND: w = st.cond[s];
      SSR_REG_EVNT: w = st.evnt[s];
      SSR_REG_ENAB: w = st.enab[s];
      SSR_REG_PTR:  w = st.ptr[s];
      SSR_REG_NTR:  w = st.ntr[s];
      default:      w = SSR_ZERO;
    endcase
    return w;
  endfunction : pick_word

  // Condition bits change with no regard to our clock
  ssr_sync2 #(
    .WIDTH(COND_W)
  ) sync_u (
    .sys_clk_in(sys_clk_in),
    .rstn_in   (rstn_in),
    .async_in  (cond_in),
    .sync_out  (cond_sync)
  );

  // The registered condition copy is the previous value for edge detection
  for (genvar g = 0; g < SSR_SETS; g++) begin : g_set
    ssr_edge_filt #(
      .WIDTH(SSR_BITS)
    ) edge_u (
      .now_in (cond_sync[g*SSR_BITS +: SSR_BITS]),
      .old_in (st_q.cond[g]),
      .ptr_in (st_q.ptr[g]),
      .ntr_in (st_q.ntr[g]),
      .hit_out(hit[g])
    );
    ssr_summary #(
      .WIDTH(SSR_BITS)
    ) sum_u (
      .event_in (st_q.evnt[g]),
      .enable_in(st_q.enab[g]),
      .flag_out (sum_bit[g])
    );
  end

  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    for (int s = 0; s < SSR_SETS; s++) begin
      st_d.cond[s] = cond_sync[s*SSR_BITS +: SSR_BITS];
      // Read clear applies to the old value; edges seen this cycle survive it
      if (rd_in && set_sel_in == SSR_SEL_W'(s) && reg_sel_in == SSR_REG_EVNT) begin
        st_d.evnt[s] = SSR_ZERO;
      end
      st_d.evnt[s] = st_d.evnt[s] | hit[s];
      if (wr_in && set_sel_in == SSR_SEL_W'(s)) begin
        unique case (reg_sel_in)
          SSR_REG_ENAB: st_d.enab[s] = wdata_in[SSR_BITS-1:0];
          SSR_REG_PTR:  st_d.ptr[s]  = wdata_in[SSR_BITS-1:0];
          SSR_REG_NTR:  st_d.ntr[s]  = wdata_in[SSR_BITS-1:0];
          default: ;
        endcase
      end
      // Preset wins over a same-cycle write, except to ptr/ntr of the user set; status_preset_in acts on all seven sets
      if (status_preset_in) begin
        if (s == int'(SSR_USER)) begin
          st_d.enab[s] = SSR_ZERO;
        end else begin
          st_d.enab[s] = SSR_PRE_EN_ONES[s] ? SSR_ONES : SSR_ZERO;
          st_d.ptr[s]  = SSR_ONES;
          st_d.ntr[s]  = SSR_ZERO;
        end
      end
    end
    if (rd_in) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = SSR_ZERO;
      for (int s = 0; s < SSR_SETS; s++) begin
        if (set_sel_in == SSR_SEL_W'(s)) begin
          st_d.rdata = pick_word(st_q, s, reg_sel_in);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Weighted sum of a 15-bit pattern is the pattern itself, zero-extended
  assign rdata_out  = {1'b0, st_q.rdata};
  assign rvalid_out = st_q.rvalid;

  always_comb begin
    for (int s = 0; s < SSR_SETS; s++) begin
      summary_out[s] = sum_bit[s];
    end
  end
endmodule : ssr_status_sets
`default_nettype wire
